// ==== lwsc_regs.vh ====
// Constants for the latency and write strobe controller (host side).
// Assumes an APB slave at 32-bit data and one pclk domain at 100 MHz.
`ifndef LWSC_REGS_VH
`define LWSC_REGS_VH
// =========================================
// Register byte offsets
`define LWSC_CTRL_OFF      12'h000
`define LWSC_BAND_OFF      12'h004
`define LWSC_CMD_OFF       12'h008
`define LWSC_STATUS_OFF    12'h00c
`define LWSC_TIMING_OFF    12'h010
`define LWSC_MRVAL_OFF     12'h014
// =========================================
// Control fields
`define LWSC_CTRL_DBI_BIT  0
`define LWSC_CTRL_WLB_BIT  1
`define LWSC_CTRL_MODE_BIT 2
`define LWSC_CTRL_ODT_LSB  4
`define LWSC_CTRL_BL32_BIT 7
`define LWSC_CTRL_RST      32'h0000_0000
`define LWSC_BAND_RST      3'h0
// Command codes written to the command register
`define LWSC_CMD_WR        2'h1
`define LWSC_CMD_RD        2'h2
`define LWSC_CMD_MRW       2'h3
// Mode register bit positions on the device
`define LWSC_MR_DBI_BIT    6
`define LWSC_MR_WLS_BIT    6
// Command frame length in link clocks
`define LWSC_FRAME_BITS    5'h10
// Turnaround in link clocks, value of table is open
`define LWSC_TURNAROUND    6'h02
// Read burst length on the strobe in link clocks
`define LWSC_RD_BURST      6'h08
`define LWSC_WPST          6'h01
`endif

// ==== lwsc_table.v ====
// Latency table lookup for each frequency band.
// Assumes band index 0..7 from the lowest band upward; output is registered.
module lwsc_table (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Lookup
    input  wire [2:0] band,
    input  wire       wl_set_b,
    input  wire       dbi_on,
    output reg  [5:0] rl_ff,
    output reg  [5:0] wl_ff,
    output reg  [5:0] nwr_ff,
    output reg  [4:0] read_to_precharge_cycles_ff,
    output reg  [4:0] won_ff,
    output reg  [5:0] woff_ff
);
    reg [5:0] nxt_rl;
    reg [5:0] nxt_wl;
    reg [5:0] nxt_nwr;
    reg [4:0] nxt_read_to_precharge_cycles;
    reg [4:0] nxt_won;
    reg [5:0] nxt_woff;

    // =========================================
    // Band rows
    always @* begin
        nxt_rl = 6'h06; nxt_wl = 6'h04; nxt_nwr = 6'h06; nxt_read_to_precharge_cycles = 5'h08;
        nxt_won = 5'h00; nxt_woff = 6'h0f;
        case (band)
            3'h0: begin
                nxt_rl = 6'h06; nxt_wl = 6'h04; nxt_nwr = 6'h06; nxt_read_to_precharge_cycles = 5'h08;
                nxt_won = 5'h00; nxt_woff = 6'h0f;
            end
            3'h1: begin
                nxt_rl = dbi_on ? 6'h0c : 6'h0a; nxt_wl = wl_set_b ? 6'h08 : 6'h06;
                nxt_nwr = 6'h0a; nxt_read_to_precharge_cycles = 5'h08; nxt_won = 5'h00;
                nxt_woff = wl_set_b ? 6'h14 : 6'h12;
            end
            3'h2: begin
                nxt_rl = dbi_on ? 6'h10 : 6'h0e; nxt_wl = wl_set_b ? 6'h0c : 6'h08;
                nxt_nwr = 6'h10; nxt_read_to_precharge_cycles = 5'h08; nxt_won = wl_set_b ? 5'h06 : 5'h00;
                nxt_woff = wl_set_b ? 6'h19 : 6'h15;
            end
            3'h3: begin
                nxt_rl = dbi_on ? 6'h16 : 6'h14; nxt_wl = wl_set_b ? 6'h12 : 6'h0a;
                nxt_nwr = 6'h14; nxt_read_to_precharge_cycles = 5'h08; nxt_won = wl_set_b ? 5'h0c : 5'h04;
                nxt_woff = wl_set_b ? 6'h20 : 6'h18;
            end
            3'h4: begin
                nxt_rl = dbi_on ? 6'h1c : 6'h18; nxt_wl = wl_set_b ? 6'h16 : 6'h0c;
                nxt_nwr = 6'h18; nxt_read_to_precharge_cycles = 5'h0a; nxt_won = wl_set_b ? 5'h0e : 5'h04;
                nxt_woff = wl_set_b ? 6'h25 : 6'h1b;
            end
            3'h5: begin
                nxt_rl = dbi_on ? 6'h20 : 6'h1c; nxt_wl = wl_set_b ? 6'h1a : 6'h0e;
                nxt_nwr = 6'h1e; nxt_read_to_precharge_cycles = 5'h0c; nxt_won = wl_set_b ? 5'h12 : 5'h06;
                nxt_woff = wl_set_b ? 6'h2a : 6'h1e;
            end
            3'h6: begin
                nxt_rl = dbi_on ? 6'h24 : 6'h20; nxt_wl = wl_set_b ? 6'h1e : 6'h10;
                nxt_nwr = 6'h22; nxt_read_to_precharge_cycles = 5'h0e; nxt_won = wl_set_b ? 5'h14 : 5'h06;
                nxt_woff = wl_set_b ? 6'h2f : 6'h21;
            end
            default: begin
                nxt_rl = dbi_on ? 6'h28 : 6'h24; nxt_wl = wl_set_b ? 6'h22 : 6'h12;
                nxt_nwr = 6'h28; nxt_read_to_precharge_cycles = 5'h10; nxt_won = wl_set_b ? 5'h18 : 5'h08;
                nxt_woff = wl_set_b ? 6'h34 : 6'h24;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rl_ff <= 6'h06; wl_ff <= 6'h04; nwr_ff <= 6'h06;
            read_to_precharge_cycles_ff <= 5'h08; won_ff <= 5'h00; woff_ff <= 6'h0f;
        end else begin
            rl_ff <= nxt_rl; wl_ff <= nxt_wl; nwr_ff <= nxt_nwr;
            read_to_precharge_cycles_ff <= nxt_read_to_precharge_cycles; won_ff <= nxt_won; woff_ff <= nxt_woff;
        end
    end
endmodule // lwsc_table

// ==== lwsc_ctrl.v ====
// Host controller: picks latency row, programs mode registers, drives strobe.
// Assumes APB master software and a device link clock arriving on a pin.
// Operation
// (R1) Device reads latency column by io_config bit 6: plain or inversion.
// (R2) Device picks write latency set A or B by latency_mode bit 6.
// (R3) Host runs the clock only inside the band of programmed values.
// (R4) Device precharges write_recovery_cycles after write with auto precharge.
// (R5) Device precharges read_to_precharge_cycles after read with auto precharge.
// (R6) Thirty-two beat bursts add eight clocks to read_to_precharge_cycles.
// (R7) Host controls write strobe in read-based or on/off window mode.
// (R8) Strobe control never relaxes command spacing; command timing wins.
// (R9) Read-based: at write, move from complement-high to differential strobe.
// (R10) Read-based: after postamble drive complement high again while clock enabled.
// (R11) Clock enable low: strobe lines may be left in any state.
// (R12) Read-based duties waived during read strobe and turnaround handover.
// (R13) On/off: strobe differential no later than write_strobe_on_delay after write.
// (R14) On/off: keep differential at least write_strobe_off_delay after last write.
// (R15) On/off: window duties waived over read burst, postamble and turnarounds.
// (R16) Read or write toggling counts toward the differential window.
// (R17) Exception window: max(0, WL-on+turnaround-preamble-gap) or turnaround.
// (R18) Termination on keeps window inside termination window; off may relax.
// (R19) Device terminates only when termination_mode field is not zero.
// (R20) Host chooses table row from its clock and programs it before commands.
//
// Added by the designer: register access over APB and the address map.
`include "lwsc_regs.vh"
module lwsc_ctrl (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Link to device
    input  wire        link_clk,
    input  wire        cke,
    output reg         cmd_valid_ff,
    output reg  [1:0]  cmd_code_ff,
    output reg  [7:0]  cmd_data_ff,
    // Write strobe pair, enables low while driven
    output reg         strobe_t_ff,
    output reg         strobe_c_ff,
    output reg         strobe_oe_n_ff,
    // Debug
    output wire [5:0]  exception_window
);
    reg  [31:0] ctrl_ff;
    reg  [2:0]  band_ff;
    reg  [1:0]  pend_ff;
    reg         busy_ff;
    reg         last_rd_ff;
    reg  [5:0]  won_cnt_ff;
    reg  [5:0]  woff_cnt_ff;
    reg  [5:0]  rd_cnt_ff;
    reg  [5:0]  ta_cnt_ff;
    reg  [1:0]  st_ff;
    reg         lk_s1_ff;
    reg         lk_s2_ff;
    reg         lk_s3_ff;
    reg         ck_s1_ff;
    reg         ck_s2_ff;
    wire [5:0]  rl;
    wire [5:0]  wl;
    wire [5:0]  write_recovery_cycles;
    wire [4:0]  read_to_precharge_cycles;
    wire [4:0]  won;
    wire [5:0]  woff;
    wire        lk_rise;
    wire        wr_en;
    wire        read_mode;
    wire        odt_on;
    wire        in_except;

    localparam ST_IDLE = 2'h0;
    localparam ST_CMD  = 2'h1;
    localparam ST_DONE = 2'h2;

    // Clamped difference, used for the exception window
    function [5:0] sat_sub;
        input [5:0] a;
        input [5:0] b;
        begin
            sat_sub = (a > b) ? (a - b) : 6'h00;
        end
    endfunction

    lwsc_table u_table (
        .pclk     (pclk),
        .presetn  (presetn),
        .band     (band_ff),
        .wl_set_b (ctrl_ff[`LWSC_CTRL_WLB_BIT]),
        .dbi_on   (ctrl_ff[`LWSC_CTRL_DBI_BIT]),
        .rl_ff    (rl),
        .wl_ff    (wl),
        .nwr_ff   (write_recovery_cycles),
        .read_to_precharge_cycles_ff  (read_to_precharge_cycles),
        .won_ff   (won),
        .woff_ff  (woff)
    );

    // =========================================
    // APB access, zero wait states
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel && penable && pwrite;
    assign read_mode = ~ctrl_ff[`LWSC_CTRL_MODE_BIT];                       // [R7]
    assign odt_on  = ctrl_ff[`LWSC_CTRL_ODT_LSB+2:`LWSC_CTRL_ODT_LSB] != 3'h0; // [R19]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `LWSC_CTRL_RST;
            band_ff <= `LWSC_BAND_RST;
        end else if (wr_en && !busy_ff) begin
            if (paddr == `LWSC_CTRL_OFF)
                ctrl_ff <= pwdata;
            if (paddr == `LWSC_BAND_OFF)
                band_ff <= pwdata[2:0];                                    // [R3] [R20]
        end
    end

    always @* begin
        case (paddr)
            `LWSC_CTRL_OFF:   prdata = ctrl_ff;
            `LWSC_BAND_OFF:   prdata = {29'h0, band_ff};
            `LWSC_STATUS_OFF: prdata = {24'h0, ck_s2_ff, in_except, strobe_oe_n_ff, last_rd_ff, 3'h0, busy_ff};
            `LWSC_TIMING_OFF: prdata = {2'h0, woff, 3'h0, won, 2'h0, wl, 2'h0, rl};
            `LWSC_MRVAL_OFF: begin
                prdata = {13'h0, ctrl_ff[`LWSC_CTRL_BL32_BIT] ? read_to_precharge_cycles + 5'h08 : read_to_precharge_cycles, 2'h0, write_recovery_cycles, 6'h0}; // [R4] [R5] [R6]
            end
            default:          prdata = 32'h0;
        endcase
    end

    // =========================================
    // Link clock sampling, two stages before use
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_s1_ff <= 1'b0; lk_s2_ff <= 1'b0; lk_s3_ff <= 1'b0;
            ck_s1_ff <= 1'b0; ck_s2_ff <= 1'b0;
        end else begin
            lk_s1_ff <= link_clk; lk_s2_ff <= lk_s1_ff; lk_s3_ff <= lk_s2_ff;
            ck_s1_ff <= cke; ck_s2_ff <= ck_s1_ff;
        end
    end
    assign lk_rise = lk_s2_ff && !lk_s3_ff;

    // =========================================
    // Exception window
    assign exception_window = odt_on ? `LWSC_TURNAROUND :                  // [R17]
        sat_sub(wl + `LWSC_TURNAROUND, {1'b0, won} + 6'h02);
    assign in_except = (rd_cnt_ff != 6'h0) || (ta_cnt_ff != 6'h0);         // [R12] [R15]

    // =========================================
    // Command sequencing; at most one command per two link rises
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= ST_IDLE; busy_ff <= 1'b0; pend_ff <= 2'h0;
            cmd_valid_ff <= 1'b0; cmd_code_ff <= 2'h0; cmd_data_ff <= 8'h0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (wr_en && paddr == `LWSC_CMD_OFF && pwdata[1:0] != 2'h0) begin
                        pend_ff <= pwdata[1:0];
                        cmd_data_ff <= pwdata[15:8];
                        busy_ff <= 1'b1;
                        st_ff <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    // Waits for turnaround so spacing is never shortened
                    if (lk_rise && ck_s2_ff && ta_cnt_ff == 6'h0) begin       // [R8]
                        cmd_valid_ff <= 1'b1;
                        cmd_code_ff <= pend_ff;
                        if (pend_ff == `LWSC_CMD_MRW && cmd_data_ff == 8'h0)
                            cmd_data_ff <= {1'b0, ctrl_ff[`LWSC_CTRL_WLB_BIT], 6'h0}; // [R2] [R20]
                        st_ff <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (lk_rise) begin
                        cmd_valid_ff <= 1'b0;
                        busy_ff <= 1'b0;
                        st_ff <= ST_IDLE;
                    end
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // =========================================
    // Strobe timers on link edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            won_cnt_ff <= 6'h0; woff_cnt_ff <= 6'h0; rd_cnt_ff <= 6'h0;
            ta_cnt_ff <= 6'h0; last_rd_ff <= 1'b0;
        end else if (lk_rise) begin
            if (st_ff == ST_DONE && cmd_code_ff == `LWSC_CMD_WR) begin
                won_cnt_ff <= {1'b0, won};                                // [R13]
                woff_cnt_ff <= woff + `LWSC_WPST;                         // [R14]
                if (last_rd_ff)
                    ta_cnt_ff <= exception_window;                        // [R18]
                last_rd_ff <= 1'b0;
            end else if (st_ff == ST_DONE && cmd_code_ff == `LWSC_CMD_RD) begin
                rd_cnt_ff <= rl + `LWSC_RD_BURST;
                ta_cnt_ff <= `LWSC_TURNAROUND;
                last_rd_ff <= 1'b1;
            end else begin
                if (won_cnt_ff != 6'h0) won_cnt_ff <= won_cnt_ff - 6'h01;
                if (woff_cnt_ff != 6'h0) woff_cnt_ff <= woff_cnt_ff - 6'h01;
                if (rd_cnt_ff != 6'h0) rd_cnt_ff <= rd_cnt_ff - 6'h01;
                if (ta_cnt_ff != 6'h0 && rd_cnt_ff == 6'h0) ta_cnt_ff <= ta_cnt_ff - 6'h01;
            end
        end
    end

    // =========================================
    // Strobe pins; driving early from the command still meets the on delay
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_t_ff <= 1'b0; strobe_c_ff <= 1'b1; strobe_oe_n_ff <= 1'b1;
        end else if (!ck_s2_ff) begin
            strobe_oe_n_ff <= 1'b1;                                       // [R11]
        end else if (in_except) begin
            strobe_oe_n_ff <= 1'b1;                                       // [R12] [R15]
        end else if (woff_cnt_ff != 6'h0) begin
            strobe_oe_n_ff <= 1'b0;                                       // [R9] [R13] [R14] [R16]
            strobe_t_ff <= lk_rise ? ~strobe_t_ff : strobe_t_ff;
            strobe_c_ff <= lk_rise ? strobe_t_ff : strobe_c_ff;
        end else if (read_mode) begin
            strobe_oe_n_ff <= 1'b0;                                       // [R10]
            strobe_t_ff <= 1'b0;
            strobe_c_ff <= 1'b1;
        end else begin
            strobe_oe_n_ff <= 1'b1;                                       // [R14]
        end
    end
endmodule // lwsc_ctrl

// ==== lwsc_ctrl_assertions.sv ====
// Concurrent checks on the ports of the strobe controller.
// Assumes one pclk domain and presetn asynchronous active low.
`include "lwsc_regs.vh"
module lwsc_chk (
    // Clock and APB answer
    input logic       pclk,
    input logic       presetn,
    input logic       pready,
    input logic       pslverr,
    // Link side
    input logic       link_clk,
    input logic       cke,
    input logic       cmd_valid_ff,
    input logic [1:0] cmd_code_ff,
    input logic [7:0] cmd_data_ff,
    input logic       strobe_t_ff,
    input logic       strobe_c_ff,
    input logic       strobe_oe_n_ff,
    input logic [5:0] exception_window
);
    // =========================================
    // Link edge age, in pclk cycles since a sampled rise
    logic       lk_ff;
    logic [3:0] lkcnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_ff    <= 1'b0;
            lkcnt_ff <= 4'hf;
        end else begin
            lk_ff    <= link_clk;
            lkcnt_ff <= (link_clk && !lk_ff) ? 4'h0 : ((lkcnt_ff == 4'hf) ? lkcnt_ff : lkcnt_ff + 4'h1);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =========================================
    // Steps
    sequence s_wr_issue;
        $rose(cmd_valid_ff) && cmd_code_ff == `LWSC_CMD_WR;
    endsequence
    sequence s_cke_low;
        !cke [*8];
    endsequence
    // =========================================
    // Checks
    chk_apb_ready: assert property (pready && !pslverr)
        else $error("apb answer not zero wait");
    chk_code_legal: assert property (cmd_valid_ff |-> cmd_code_ff != 2'h0)
        else $error("command with empty code");
    chk_cmd_hold: assert property (cmd_valid_ff && $past(cmd_valid_ff) |-> $stable({cmd_code_ff, cmd_data_ff}))
        else $error("command changed while valid");
    chk_pulse_len: assert property ($rose(cmd_valid_ff) |-> cmd_valid_ff [*8])
        else $error("command pulse too short");
    chk_link_sync: assert property ($rose(cmd_valid_ff) |-> lkcnt_ff >= 4'h1 && lkcnt_ff <= 4'h4)
        else $error("command not aligned to link rise");
    chk_wr_drive: assert property (s_wr_issue |-> ##[1:20] !strobe_oe_n_ff)
        else $error("strobe not driven after write");
    chk_diff_pair: assert property (!strobe_oe_n_ff |-> strobe_t_ff != strobe_c_ff)
        else $error("driven strobe not differential");
    chk_off_hold: assert property ($fell(strobe_oe_n_ff) |-> !strobe_oe_n_ff [*8])
        else $error("strobe released too soon");
    chk_cke_low: assert property (s_cke_low |-> ##[0:24] strobe_oe_n_ff)
        else $error("strobe held with clock enable low");
    chk_excp_bound: assert property (exception_window <= 6'h0a)
        else $error("exception window out of range");
endmodule // lwsc_chk
bind lwsc_ctrl lwsc_chk u_chk (.pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .cke(cke), .cmd_valid_ff(cmd_valid_ff), .cmd_code_ff(cmd_code_ff),
    .cmd_data_ff(cmd_data_ff), .strobe_t_ff(strobe_t_ff), .strobe_c_ff(strobe_c_ff),
    .strobe_oe_n_ff(strobe_oe_n_ff), .exception_window(exception_window));

// ==== lwsc_dev_model.sv ====
// Device model: makes the command clock, captures commands, watches the strobe.
// Assumes commands sampled at link rise and strobe enable low while driven.
`include "lwsc_regs.vh"
module lwsc_dev_model (
    // Command clock out
    output logic       link_clk,
    // From host
    input  logic       cke,
    input  logic       cmd_valid,
    input  logic [1:0] cmd_code,
    input  logic [7:0] cmd_data,
    input  logic       strobe_t,
    input  logic       strobe_c,
    input  logic       strobe_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mr_ff;
    logic       set_b;
    int         n_wr;
    int         n_rd;
    int         n_skew;
    // Odd start offset keeps every link edge 2 ns ahead of a pclk rise, never on it
    initial begin
        link_clk = 1'b0;
        mr_ff    = 8'h00;
        n_wr     = 0;
        n_rd     = 0;
        n_skew   = 0;
        #3;
        forever #80 link_clk = ~link_clk;
    end
    always @(posedge link_clk) begin
        if (cmd_valid && cke) begin
            case (cmd_code)
                2'h1: n_wr++;
                2'h2: n_rd++;
                2'h3: mr_ff <= cmd_data;
                default: ;
            endcase
        end
        // Strobe ignored while clock enable is low
        if (cke && !strobe_oe_n && strobe_t == strobe_c) n_skew++;
    end
    assign set_b = mr_ff[`LWSC_MR_WLS_BIT];
endmodule // lwsc_dev_model

// ==== tb_latency_and_write_strobe_control.sv ====
// Self-checking bench for the latency and write strobe controller.
// Assumes the device model makes the link clock and the checker is bound.
`include "lwsc_regs.vh"
module tb_latency_and_write_strobe_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, cke, pready, pslverr, link_clk;
    logic        cmd_valid_ff, strobe_t_ff, strobe_c_ff, strobe_oe_n_ff;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  cmd_code_ff;
    logic [7:0]  cmd_data_ff;
    logic [5:0]  exception_window;
    int          bad_count, tests_run, n;
    // Columns: band, ctrl, rl, wl, won, woff, nwr, read_to_precharge_cycles, exception
    int rows[5][9] = '{'{0, 'h00, 6, 4, 0, 15, 6, 8, 4}, '{7, 'h03, 40, 34, 24, 52, 40, 16, 10},
        '{4, 'h02, 24, 22, 14, 37, 24, 10, 8}, '{3, 'h91, 22, 10, 4, 24, 20, 16, 2},
        '{5, 'h00, 28, 14, 6, 30, 30, 12, 8}};
    lwsc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_clk(link_clk), .cke(cke), .cmd_valid_ff(cmd_valid_ff), .cmd_code_ff(cmd_code_ff),
        .cmd_data_ff(cmd_data_ff), .strobe_t_ff(strobe_t_ff), .strobe_c_ff(strobe_c_ff),
        .strobe_oe_n_ff(strobe_oe_n_ff), .exception_window(exception_window));
    lwsc_dev_model model (.link_clk(link_clk), .cke(cke), .cmd_valid(cmd_valid_ff), .cmd_code(cmd_code_ff),
        .cmd_data(cmd_data_ff), .strobe_t(strobe_t_ff), .strobe_c(strobe_c_ff), .strobe_oe_n(strobe_oe_n_ff));
    always #5 pclk = ~pclk;
    // =========================================
    // Tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmd(input logic [1:0] c, input logic [7:0] d);
        apb(1'b1, `LWSC_CMD_OFF, {16'h0, d, 6'h0, c}, rd);
    endtask
    // Polls busy; bounded so a stuck flag shows as a mismatch
    task automatic wait_idle();
        int k;
        k = 0;
        do begin apb(1'b0, `LWSC_STATUS_OFF, 32'h0, rd); k++; end while (rd[0] !== 1'b0 && k < 3000);
        chk("busy", 32'h0, 32'(k >= 3000));
        repeat (2) @(posedge pclk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #500000;
        bad_count++;
        wrap_up();
    end
    // =========================================
    // Main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, bad_count, tests_run} = '0;
        cke = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("strobe_rst", 32'h1, 32'(strobe_oe_n_ff & strobe_c_ff));
        apb(1'b0, `LWSC_CTRL_OFF, 32'h0, rd);
        chk("ctrl_rst", `LWSC_CTRL_RST, rd);
        foreach (rows[i]) begin
            apb(1'b1, `LWSC_CTRL_OFF, 32'(rows[i][1]), rd);
            apb(1'b1, `LWSC_BAND_OFF, 32'(rows[i][0]), rd);
            repeat (2) @(posedge pclk);
            apb(1'b0, `LWSC_TIMING_OFF, 32'h0, rd);
            chk("timing", {2'b0, 6'(rows[i][5]), 3'b0, 5'(rows[i][4]), 2'b0, 6'(rows[i][3]), 2'b0, 6'(rows[i][2])}, rd);
            apb(1'b0, `LWSC_MRVAL_OFF, 32'h0, rd);
            chk("mrval", {13'b0, 5'(rows[i][7]), 2'b0, 6'(rows[i][6]), 6'b0}, rd);
            chk("excp", 32'(rows[i][8]), 32'(exception_window));
        end
        $display("table test done");
        apb(1'b1, `LWSC_CTRL_OFF, 32'h0, rd);
        apb(1'b1, `LWSC_BAND_OFF, 32'h0, rd);
        n = model.n_wr;
        cmd(`LWSC_CMD_WR, 8'h5a);
        cmd(`LWSC_CMD_WR, 8'h33);
        wait_idle();
        chk("wr_refused", 32'(n + 1), 32'(model.n_wr));
        // Strobe keeps toggling for the off delay after busy clears
        repeat (300) @(posedge pclk);
        chk("read_based_idle", 32'h1, {29'h0, strobe_oe_n_ff, strobe_t_ff, strobe_c_ff});
        $display("read-based write done");
        apb(1'b1, `LWSC_CTRL_OFF, 32'h4, rd);
        cmd(`LWSC_CMD_WR, 8'h11);
        wait_idle();
        chk("onoff_drive", 32'h0, 32'(strobe_oe_n_ff));
        repeat (300) @(posedge pclk);
        chk("onoff_release", 32'h1, 32'(strobe_oe_n_ff));
        apb(1'b1, `LWSC_CTRL_OFF, 32'h2, rd);
        cmd(`LWSC_CMD_MRW, 8'h00);
        wait_idle();
        chk("mrw_auto", 32'h1, 32'(model.set_b));
        $display("mode write done");
        n = model.n_wr;
        @(posedge pclk) cke <= 1'b0;
        cmd(`LWSC_CMD_WR, 8'h22);
        repeat (60) @(posedge pclk);
        apb(1'b0, `LWSC_STATUS_OFF, 32'h0, rd);
        chk("cke_low", {n, 2'b10}, {model.n_wr, strobe_oe_n_ff, rd[7]});
        @(posedge pclk) cke <= 1'b1;
        wait_idle();
        chk("cke_resume", 32'(n + 1), 32'(model.n_wr));
        chk("no_skew", 32'h0, 32'(model.n_skew));
        $display("clock enable test done");
        // Read last, so no later write falls in its exception window
        n = model.n_rd;
        cmd(`LWSC_CMD_RD, 8'h00);
        wait_idle();
        apb(1'b0, `LWSC_STATUS_OFF, 32'h0, rd);
        chk("last_read", 32'(n + 1) | 32'h100, 32'(model.n_rd) | {23'h0, rd[4], 8'h0});
        $display("read done");
        apb(1'b1, 12'h020, 32'hffff_ffff, rd);
        apb(1'b0, 12'h020, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `LWSC_CTRL_OFF, 32'h0, rd);
        chk("ctrl_rerst", `LWSC_CTRL_RST, rd);
        $display("unmapped and reset done");
        wrap_up();
    end
endmodule // tb_latency_and_write_strobe_control
